/* logic/flash_cmd_check.sv */
// command decode and protection window check for one pending command
`timescale 1ns/1ns
`default_nettype none
module flash_cmd_check
(
	input  wire logic [7:0]                            code,
	input  wire logic [flash_ctrl_pkg::ADDR_W-1:0]     addr,
	input  wire logic [flash_ctrl_pkg::BOUNDARY_W-1:0] boundary,
	input  wire logic                                  prot_disable,
	output logic                                       legal,
	output logic                                       prog_erase,
	output logic                                       prot_hit
);
	import flash_ctrl_pkg::*;

	logic [ADDR_W-1:0] last_open;
	logic              any_protected;

	// decode of the five accepted codes, all others illegal
	assign legal = (code == CMD_BLANK_CHECK) || (code == CMD_BYTE_PROG) ||
		(code == CMD_BURST_PROG) || (code == CMD_PAGE_ERASE) || (code == CMD_MASS_ERASE);
	assign prog_erase = legal && (code != CMD_BLANK_CHECK);

	// the protected block sits above the last open address
	assign last_open     = {boundary, {PAGE_BITS{1'b1}}};
	assign any_protected = !prot_disable && (last_open != {ADDR_W{1'b1}});

	// a page erase is judged by its page, a mass erase by any protection at all
	always_comb
	begin
		prot_hit = 1'b0;
		if (!prot_disable && prog_erase)
		begin
			case (code)
				CMD_MASS_ERASE: prot_hit = any_protected;
				CMD_PAGE_ERASE: prot_hit = {addr[ADDR_W-1:PAGE_BITS], {PAGE_BITS{1'b1}}} > last_open;
				default:        prot_hit = addr > last_open;
			endcase
		end
	end
endmodule
`default_nettype wire

/* logic/flash_cmd_ctrl.sv */
// flash command controller: apb registers, command sequencing, protection
`timescale 1ns/1ns
`default_nettype none
module flash_cmd_ctrl
(
	input  wire logic                           clk,
	input  wire logic                           rst_b,
	input  wire logic                           ce,
	input  wire logic                           psel,
	input  wire logic                           penable,
	input  wire logic                           pwrite,
	input  wire logic [7:0]                     paddr,
	input  wire logic [31:0]                    pwdata,
	output logic      [31:0]                    prdata,
	output logic                                pready,
	output logic                                pslverr,
	input  wire logic                           arr_wr,
	input  wire logic [flash_ctrl_pkg::ADDR_W-1:0] arr_addr,
	input  wire logic [7:0]                     arr_data,
	input  wire logic [7:0]                     stored_protection_byte,
	input  wire logic [1:0]                     stored_security_code,
	input  wire logic                           debug_prot_wr,
	input  wire logic [7:0]                     debug_prot_data,
	input  wire logic                           stop_entry,
	output logic                                key_wr,
	output logic      [2:0]                     key_index,
	output logic      [7:0]                     key_data,
	input  wire logic                           key_match,
	output flash_ctrl_pkg::array_cmd_t          array_cmd,
	output logic                                array_cmd_valid,
	input  wire logic                           array_cmd_ready,
	input  wire logic                           array_busy,
	input  wire logic                           array_done,
	input  wire logic                           array_blank_ok,
	output logic      [7:0]                     flash_clock_divider,
	output logic      [1:0]                     security_state_code
);
	import flash_ctrl_pkg::*;

	logic [7:0]            flash_config;
	logic [7:0]            flash_protection;
	logic [7:0]            flash_command;
	logic                  divider_loaded;
	logic                  loaded;
	logic                  cmd_buffer_empty;
	logic                  cmd_complete;
	logic                  protect_violation;
	logic                  access_error;
	logic                  array_blank;
	logic [7:0]            running_code;
	logic [ADDR_W-1:0]     pend_addr;
	logic [7:0]            pend_data;
	seq_state_t            seq;
	logic                  wr_fire;
	logic                  rd_setup;
	logic                  mapped;
	logic                  cmd_legal;
	logic                  cmd_prog_erase;
	logic                  cmd_prot_hit;
	logic                  key_hit;
	logic                  launch_req;
	logic                  launch_ok;
	logic                  launch_viol;
	logic                  launch_err;
	logic                  cmd_wr;
	logic                  cmd_wr_err;
	logic                  arr_wr_err;
	logic                  stop_err;
	logic                  transfer;
	logic                  blank_pass;
	logic [7:0]            status_view;
	logic [7:0]            next_prdata;

	function automatic logic in_key_window(input logic [ADDR_W-1:0] a);
		return (a >= KEY_WINDOW_FIRST) && (a <= KEY_WINDOW_LAST);
	endfunction

	function automatic logic cmd_legal_in(input logic [7:0] c);
		return (c == CMD_BLANK_CHECK) || (c == CMD_BYTE_PROG) || (c == CMD_BURST_PROG) ||
			(c == CMD_PAGE_ERASE) || (c == CMD_MASS_ERASE);
	endfunction

	// apb: one wait state, so read data and pready leave flip-flops
	assign wr_fire  = ce && psel && penable && pready && pwrite;
	assign rd_setup = psel && penable && !pready;
	assign mapped   = (paddr == OFS_DIVIDER) || (paddr == OFS_CONFIG) ||
		(paddr == OFS_PROTECTION) || (paddr == OFS_STATUS) ||
		(paddr == OFS_COMMAND) || (paddr == OFS_SECURITY);

	assign status_view = {cmd_buffer_empty, cmd_complete, protect_violation, access_error,
		1'b0, array_blank, 2'b00};

	always_comb
	begin
		next_prdata = 8'h00;
		case (paddr)
			OFS_DIVIDER:    next_prdata = {divider_loaded, flash_clock_divider[6:0]};
			OFS_CONFIG:     next_prdata = flash_config;
			OFS_PROTECTION: next_prdata = flash_protection;
			OFS_STATUS:     next_prdata = status_view;
			OFS_COMMAND:    next_prdata = flash_command;
			OFS_SECURITY:   next_prdata = {6'h00, security_state_code};
			default:        next_prdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else if (ce)
		begin
			pready  <= rd_setup;
			pslverr <= rd_setup && !mapped;
			prdata  <= rd_setup && !pwrite ? {24'h00_0000, next_prdata} : 32'h0000_0000;
		end
	end

	flash_cmd_check u_check
	(
		.code         (flash_command),
		.addr         (pend_addr),
		.boundary     (flash_protection[7:1]),
		.prot_disable (flash_protection[PROT_DISABLE_BIT]),
		.legal        (cmd_legal),
		.prog_erase   (cmd_prog_erase),
		.prot_hit     (cmd_prot_hit)
	);

	// sequencing events
	assign key_hit     = ce && arr_wr && flash_config[CFG_KEY_WRITE] && in_key_window(arr_addr);
	assign arr_wr_err  = ce && arr_wr && !key_hit && (seq != seq_idle || !cmd_buffer_empty);
	assign cmd_wr      = wr_fire && (paddr == OFS_COMMAND);
	assign cmd_wr_err  = cmd_wr && (seq != seq_have_addr || !cmd_legal_in(pwdata[7:0]));
	assign launch_req  = wr_fire && (paddr == OFS_STATUS) && pwdata[ST_BUF_EMPTY] && cmd_buffer_empty;
	assign launch_err  = launch_req && (seq != seq_have_cmd || !cmd_legal ||
		(cmd_prog_erase && !divider_loaded));
	assign launch_viol = launch_req && !launch_err && cmd_prot_hit;
	assign launch_ok   = launch_req && !launch_err && !cmd_prot_hit;
	assign transfer    = ce && array_cmd_valid && array_cmd_ready;
	assign stop_err    = ce && stop_entry && (array_busy || array_cmd_valid);
	assign blank_pass  = ce && array_done && running_code == CMD_BLANK_CHECK && array_blank_ok;

	// registration order: array write, command code, launch
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			seq       <= seq_idle;
			pend_addr <= '0;
			pend_data <= 8'h00;
		end
		else if (ce)
		begin
			case (seq)
				seq_idle:
				begin
					if (arr_wr && !key_hit && cmd_buffer_empty)
					begin
						seq       <= seq_have_addr;
						pend_addr <= arr_addr;
						pend_data <= arr_data;
					end
				end
				seq_have_addr:
				begin
					if (arr_wr_err || cmd_wr_err)
						seq <= seq_idle;
					else if (cmd_wr)
						seq <= seq_have_cmd;
				end
				seq_have_cmd:
				begin
					if (arr_wr_err || cmd_wr || launch_req)
						seq <= seq_idle;
				end
				default: seq <= seq_idle;
			endcase
		end
	end

	// key writes never start a command while the key path is open
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			key_wr    <= 1'b0;
			key_index <= 3'h0;
			key_data  <= 8'h00;
		end
		else if (ce)
		begin
			key_wr <= key_hit;
			if (key_hit)
			begin
				key_index <= arr_addr[2:0];
				key_data  <= arr_data;
			end
		end
	end

	// software registers; the stored copies are caught on the first enabled edge
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			loaded              <= 1'b0;
			flash_protection    <= PROTECTION_RESET;
			flash_config        <= CONFIG_RESET;
			flash_command       <= COMMAND_RESET;
			flash_clock_divider <= DIVIDER_RESET;
			divider_loaded      <= 1'b0;
		end
		else if (ce)
		begin
			if (!loaded)
			begin
				loaded           <= 1'b1;
				flash_protection <= stored_protection_byte;
			end
			else if (debug_prot_wr)
				flash_protection <= debug_prot_data;
			else if (wr_fire && paddr == OFS_PROTECTION && !flash_protection[PROT_DISABLE_BIT] &&
				pwdata[7:1] < flash_protection[7:1])
				flash_protection[7:1] <= pwdata[7:1];
			if (wr_fire && paddr == OFS_CONFIG)
				flash_config <= pwdata[7:0];
			if (cmd_wr)
				flash_command <= pwdata[7:0];
			if (wr_fire && paddr == OFS_DIVIDER)
			begin
				flash_clock_divider <= {1'b0, pwdata[6:0]};
				divider_loaded      <= 1'b1;
			end
		end
	end

	// security code: stored copy at start, unsecured after blank pass or key match
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			security_state_code <= SECURITY_RESET;
		else if (ce)
		begin
			if (blank_pass || key_match)
				security_state_code <= SEC_UNSECURED;
			else if (!loaded)
				security_state_code <= stored_security_code;
		end
	end

	// command buffer toward the array engine; only a burst frees it at transfer
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			array_cmd_valid  <= 1'b0;
			array_cmd        <= '0;
			running_code     <= 8'h00;
			cmd_buffer_empty <= 1'b1;
			cmd_complete     <= 1'b1;
		end
		else if (ce)
		begin
			if (stop_err)
				array_cmd_valid <= 1'b0;
			else if (launch_ok)
			begin
				array_cmd_valid <= 1'b1;
				array_cmd       <= '{code: flash_command, addr: pend_addr, data: pend_data};
			end
			else if (transfer)
				array_cmd_valid <= 1'b0;
			if (transfer)
				running_code <= array_cmd.code;
			if (launch_ok)
				cmd_buffer_empty <= 1'b0;
			else if (stop_err || (transfer && array_cmd.code == CMD_BURST_PROG) ||
				(array_done && !array_cmd_valid))
				cmd_buffer_empty <= 1'b1;
			// the flag is a register, so it trails the idle condition by one edge
			cmd_complete <= !launch_ok && cmd_buffer_empty && !array_cmd_valid &&
				!array_busy;
		end
	end

	// sticky flags: a hardware set in the same cycle as a clear wins
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			protect_violation <= 1'b0;
			access_error      <= 1'b0;
			array_blank       <= 1'b0;
		end
		else if (ce)
		begin
			if (launch_viol)
				protect_violation <= 1'b1;
			else if (wr_fire && paddr == OFS_STATUS && pwdata[ST_VIOLATION])
				protect_violation <= 1'b0;
			if (launch_err || cmd_wr_err || arr_wr_err || stop_err)
				access_error <= 1'b1;
			else if (wr_fire && paddr == OFS_STATUS && pwdata[ST_ACCESS_ERR])
				access_error <= 1'b0;
			if (blank_pass)
				array_blank <= 1'b1;
			else if (launch_ok)
				array_blank <= 1'b0;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_key_steered: assert property (key_hit |=> key_wr && seq == $past(seq))
		else $error("key window write was not steered to key logic");
	a_key_starts_cmd: assert property (ce && arr_wr && !flash_config[CFG_KEY_WRITE] &&
		in_key_window(arr_addr) && seq == seq_idle && cmd_buffer_empty
		|=> seq == seq_have_addr && !key_wr)
		else $error("key window write did not begin a command");
	a_prot_tighten: assert property (loaded && $changed(flash_protection) &&
		!$past(debug_prot_wr) && $past(loaded) |-> flash_protection[7:1] < $past(flash_protection[7:1]))
		else $error("protection loosened by software");
	a_prot_disabled: assert property (wr_fire && paddr == OFS_PROTECTION && loaded &&
		flash_protection[PROT_DISABLE_BIT] && !debug_prot_wr |=> $stable(flash_protection))
		else $error("protection changed while disabled");
	a_launch_fills: assert property (launch_ok |=> !cmd_buffer_empty && array_cmd_valid
		&& !cmd_complete && !array_blank)
		else $error("launch did not fill the buffer");
	a_viol_drops: assert property (launch_viol |=> protect_violation && !array_cmd_valid)
		else $error("protected command was not dropped");
	a_illegal_code: assert property (cmd_wr && !cmd_legal_in(pwdata[7:0]) |=> access_error)
		else $error("illegal code did not flag access error");
	a_divider_gate: assert property (launch_req && cmd_prog_erase && !divider_loaded
		|=> access_error && !array_cmd_valid ##1 !array_cmd_valid)
		else $error("program or erase ran before divider write");
	a_blank_pass: assert property (blank_pass |=> array_blank &&
		security_state_code == SEC_UNSECURED)
		else $error("blank pass not recorded");
	a_accerr_clear: assert property (ce && access_error && wr_fire && paddr == OFS_STATUS &&
		!pwdata[ST_ACCESS_ERR] |=> access_error)
		else $error("writing zero cleared access error");
endmodule
`default_nettype wire

/* pkg/flash_ctrl_pkg.sv */
// constants, field layout and types shared by the flash command controller
package flash_ctrl_pkg;

	localparam int          ADDR_W           = 16;
	localparam int          PAGE_BITS        = 9;
	localparam int          BOUNDARY_W       = 7;

	localparam logic [7:0]  OFS_DIVIDER      = 8'h00;
	localparam logic [7:0]  OFS_CONFIG       = 8'h04;
	localparam logic [7:0]  OFS_PROTECTION   = 8'h08;
	localparam logic [7:0]  OFS_STATUS       = 8'h0c;
	localparam logic [7:0]  OFS_COMMAND      = 8'h10;
	localparam logic [7:0]  OFS_SECURITY     = 8'h14;

	localparam int          CFG_KEY_WRITE    = 5;
	localparam int          DIV_LOADED_BIT   = 7;
	localparam int          PROT_DISABLE_BIT = 0;
	localparam int          ST_BUF_EMPTY     = 7;
	localparam int          ST_COMPLETE      = 6;
	localparam int          ST_VIOLATION     = 5;
	localparam int          ST_ACCESS_ERR    = 4;
	localparam int          ST_BLANK         = 2;

	localparam logic [7:0]  DIVIDER_RESET    = 8'h00;
	localparam logic [7:0]  CONFIG_RESET     = 8'h00;
	localparam logic [7:0]  COMMAND_RESET    = 8'h00;
	localparam logic [7:0]  PROTECTION_RESET = 8'hff;
	localparam logic [1:0]  SECURITY_RESET   = 2'h3;
	localparam logic [1:0]  SEC_UNSECURED    = 2'h2;

	localparam logic [7:0]  CMD_BLANK_CHECK  = 8'h05;
	localparam logic [7:0]  CMD_BYTE_PROG    = 8'h20;
	localparam logic [7:0]  CMD_BURST_PROG   = 8'h25;
	localparam logic [7:0]  CMD_PAGE_ERASE   = 8'h40;
	localparam logic [7:0]  CMD_MASS_ERASE   = 8'h41;

	localparam logic [15:0] KEY_WINDOW_FIRST = 16'hffb0;
	localparam logic [15:0] KEY_WINDOW_LAST  = 16'hffb7;

	typedef struct packed {
		logic [7:0]        code;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        data;
	} array_cmd_t;

	typedef enum {
		seq_idle,
		seq_have_addr,
		seq_have_cmd
	} seq_state_t;

endpackage

/* verification/tb.sv */
// self-checking bench for the flash command controller
`timescale 1ns/1ns
`default_nettype none
module tb;
	import flash_ctrl_pkg::*;
	logic              clk = 1'b0;
	logic              rst_b = 1'b0;
	logic              ce = 1'b1;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [7:0]        paddr = 8'h00;
	logic [31:0]       pwdata = 32'h0;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic              arr_wr = 1'b0;
	logic [ADDR_W-1:0] arr_addr = 16'h0000;
	logic [7:0]        arr_data = 8'h00;
	logic [7:0]        stored_protection_byte = 8'h7e;
	logic [1:0]        stored_security_code = 2'h0;
	logic              debug_prot_wr = 1'b0;
	logic [7:0]        debug_prot_data = 8'h00;
	logic              stop_entry = 1'b0;
	logic              key_wr;
	logic [2:0]        key_index;
	logic [7:0]        key_data;
	logic              key_match = 1'b0;
	array_cmd_t        array_cmd;
	logic              array_cmd_valid;
	logic              array_cmd_ready = 1'b1;
	logic              array_busy = 1'b0;
	logic              array_done = 1'b0;
	logic              array_blank_ok = 1'b0;
	logic [7:0]        flash_clock_divider;
	logic [1:0]        security_state_code;
	int                error_cnt = 0;
	int                comparisons = 0;
	int                eng_cnt = 0;
	logic              last_slverr;
	logic [7:0]        rd;
	logic [7:0]        codes [5] = '{CMD_BLANK_CHECK, CMD_BYTE_PROG, CMD_BURST_PROG,
		CMD_PAGE_ERASE, CMD_MASS_ERASE};

	always #5 clk = ~clk;

	flash_cmd_ctrl i_flash_cmd_ctrl (.clk(clk), .rst_b(rst_b), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .arr_wr(arr_wr), .arr_addr(arr_addr),
		.arr_data(arr_data), .stored_protection_byte(stored_protection_byte),
		.stored_security_code(stored_security_code), .debug_prot_wr(debug_prot_wr),
		.debug_prot_data(debug_prot_data), .stop_entry(stop_entry), .key_wr(key_wr),
		.key_index(key_index), .key_data(key_data), .key_match(key_match),
		.array_cmd(array_cmd), .array_cmd_valid(array_cmd_valid),
		.array_cmd_ready(array_cmd_ready), .array_busy(array_busy), .array_done(array_done),
		.array_blank_ok(array_blank_ok), .flash_clock_divider(flash_clock_divider),
		.security_state_code(security_state_code));

	// engine stays busy long enough that status reads see a command in flight
	always @(posedge clk)
	begin
		array_done <= 1'b0;
		if (eng_cnt != 0)
		begin
			eng_cnt <= eng_cnt - 1;
			if (eng_cnt == 1)
			begin
				array_busy <= 1'b0;
				array_done <= 1'b1;
			end
		end
		else if (array_cmd_valid === 1'b1)
		begin
			eng_cnt <= 20;
			array_busy <= 1'b1;
			array_blank_ok <= (array_cmd.code === CMD_BLANK_CHECK);
		end
	end

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
			error_cnt++;
		end
	endtask

	task automatic timeout(input string name);
		$display("MISMATCH %s expected handshake seen none", name);
		error_cnt++;
		wrap_up();
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
		begin
			if (n == 20)
				timeout("pready");
			@(posedge clk);
			n++;
		end
		rd = prdata[7:0];
		last_slverr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
		apb(1'b0, a, 8'h00);
		check(name, {24'h0, exp}, {24'h0, rd});
	endtask

	task automatic arr_poke(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		arr_wr <= 1'b1;
		arr_addr <= a;
		arr_data <= d;
		@(posedge clk);
		arr_wr <= 1'b0;
	endtask

	task automatic launch(input logic [15:0] a, input logic [7:0] code);
		arr_poke(a, 8'h5a);
		wr(OFS_COMMAND, code);
		wr(OFS_STATUS, 8'h80);
	endtask

	// waits for the issued command and checks what reaches the array
	task automatic expect_issue(input logic [15:0] a, input logic [7:0] code);
		int n;
		n = 0;
		while (array_cmd_valid !== 1'b1)
		begin
			if (n == 20)
				timeout("array_cmd_valid");
			@(posedge clk);
			n++;
		end
		check("array_cmd", {code, a, 8'h5a}, array_cmd);
	endtask

	task automatic wait_done();
		int n;
		n = 0;
		while (array_done !== 1'b1)
		begin
			if (n == 40)
				timeout("array_done");
			@(posedge clk);
			n++;
		end
		@(posedge clk);
		@(posedge clk);
	endtask

	task automatic do_reset();
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk);
	endtask

	initial
	begin
		do_reset();
		rd_chk("protection", OFS_PROTECTION, 8'h7e);
		rd_chk("security", OFS_SECURITY, 8'h00);
		rd_chk("status", OFS_STATUS, 8'hc0);
		apb(1'b0, 8'h3c, 8'h00);
		check("unmapped pslverr", 32'h1, {31'h0, last_slverr});
		$display("test reset done");
		launch(16'h0100, CMD_BYTE_PROG);
		rd_chk("status", OFS_STATUS, 8'hd0);
		wr(OFS_STATUS, 8'h00);
		rd_chk("status", OFS_STATUS, 8'hd0);
		wr(OFS_STATUS, 8'h10);
		rd_chk("status", OFS_STATUS, 8'hc0);
		arr_poke(16'h0100, 8'h5a);
		wr(OFS_COMMAND, 8'h33);
		rd_chk("status", OFS_STATUS, 8'hd0);
		wr(OFS_STATUS, 8'h10);
		wr(OFS_DIVIDER, 8'h13);
		rd_chk("divider", OFS_DIVIDER, 8'h93);
		check("divider out", 32'h13, {24'h0, flash_clock_divider});
		$display("test errors done");
		wr(OFS_PROTECTION, 8'h3c);
		rd_chk("protection", OFS_PROTECTION, 8'h3c);
		wr(OFS_PROTECTION, 8'h50);
		rd_chk("protection", OFS_PROTECTION, 8'h3c);
		launch(16'h3e00, CMD_BYTE_PROG);
		rd_chk("status", OFS_STATUS, 8'he0);
		check("no issue", 32'h0, {31'h0, array_cmd_valid});
		wr(OFS_STATUS, 8'h20);
		rd_chk("status", OFS_STATUS, 8'hc0);
		launch(16'h3dff, CMD_BYTE_PROG);
		expect_issue(16'h3dff, CMD_BYTE_PROG);
		wait_done();
		launch(16'h0000, CMD_MASS_ERASE);
		rd_chk("status mass", OFS_STATUS, 8'he0);
		wr(OFS_STATUS, 8'h20);
		$display("test protection done");
		@(posedge clk);
		debug_prot_wr <= 1'b1;
		debug_prot_data <= 8'hfe;
		@(posedge clk);
		debug_prot_wr <= 1'b0;
		rd_chk("protection", OFS_PROTECTION, 8'hfe);
		for (int i = 0; i < 5; i++)
		begin
			launch(16'h0400, codes[i]);
			expect_issue(16'h0400, codes[i]);
			rd_chk("status busy", OFS_STATUS, (i == 2) ? 8'h80 : 8'h00);
			wait_done();
			rd_chk("status done", OFS_STATUS, (i == 0) ? 8'hc4 : 8'hc0);
		end
		rd_chk("security blank", OFS_SECURITY, 8'h02);
		$display("test commands done");
		wr(OFS_CONFIG, 8'h20);
		arr_poke(16'hffb3, 8'ha7);
		#1;
		check("key_wr", 32'h1, {31'h0, key_wr});
		check("key", 32'h3a7, {21'h0, key_index, key_data});
		wr(OFS_CONFIG, 8'h00);
		arr_poke(16'hffb0, 8'h5a);
		#1;
		check("key_wr", 32'h0, {31'h0, key_wr});
		wr(OFS_COMMAND, CMD_BYTE_PROG);
		wr(OFS_STATUS, 8'h80);
		expect_issue(16'hffb0, CMD_BYTE_PROG);
		wait_done();
		$display("test key window done");
		stored_protection_byte <= 8'h81;
		do_reset();
		rd_chk("protection", OFS_PROTECTION, 8'h81);
		wr(OFS_PROTECTION, 8'h02);
		rd_chk("protection", OFS_PROTECTION, 8'h81);
		wr(OFS_DIVIDER, 8'h01);
		launch(16'hff00, CMD_BYTE_PROG);
		expect_issue(16'hff00, CMD_BYTE_PROG);
		@(posedge clk);
		stop_entry <= 1'b1;
		@(posedge clk);
		stop_entry <= 1'b0;
		rd_chk("status stop", OFS_STATUS, 8'h90);
		wait_done();
		rd_chk("status stop done", OFS_STATUS, 8'hd0);
		wr(OFS_STATUS, 8'h10);
		// security came back secure from the stored copy; a frozen clock must ignore a match
		rd_chk("security", OFS_SECURITY, 8'h00);
		@(posedge clk);
		ce <= 1'b0;
		key_match <= 1'b1;
		@(posedge clk);
		key_match <= 1'b0;
		ce <= 1'b1;
		rd_chk("security frozen", OFS_SECURITY, 8'h00);
		@(posedge clk);
		key_match <= 1'b1;
		@(posedge clk);
		key_match <= 1'b0;
		rd_chk("security", OFS_SECURITY, 8'h02);
		check("security out", 32'h2, {30'h0, security_state_code});
		$display("test disabled protection done");
		wrap_up();
	end
endmodule
`default_nettype wire
